//--- refresh_pkg.sv
// Purpose: Shared constants for the refresh sequencer and its clock source.
// Assumes: 50 MHz system clock on both ends.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package refresh_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned NUM_CHANNELS = 10;
  localparam logic [3:0] FIRST_CHANNEL = 4'h0;
  localparam logic [3:0] LAST_CHANNEL = 4'h9;
  // Internal oscillator, about 21 kHz: half period in cycles, rounded down.
  localparam int unsigned INT_OSC_HZ = 21_000;
  localparam int unsigned INT_HALF_CYCLES = CLK_HZ / (2 * INT_OSC_HZ);
  // External clock limits: at most 70 kHz, pulses at least 4 us wide.
  localparam int unsigned EXT_MAX_HZ = 70_000;
  localparam int unsigned EXT_MIN_PULSE_NS = 4_000;
  localparam int unsigned EXT_MIN_PERIOD_CYCLES =
    (CLK_HZ + EXT_MAX_HZ - 1) / EXT_MAX_HZ;
  localparam int unsigned EXT_MIN_PULSE_CYCLES =
    (EXT_MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Duty cycle must exceed 30 percent.
  localparam int unsigned EXT_MIN_DUTY_PCT = 30;
  localparam logic [15:0] EXT_DEFAULT_HIGH = 16'h0190;
  localparam logic [15:0] EXT_DEFAULT_LOW = 16'h0190;
  localparam logic [15:0] EXT_DEFAULT_DELAY = 16'h0064;
  localparam logic RESET_SOURCE_SELECT = 1'b0;
endpackage

//--- refresh_link_if.sv
// Purpose: Joins the refresh sequencer to its external clock source.
// Assumes: The testbench resolves the refresh clock pin from the enables.
// Notes: No clocking block; pin is split into in, out and enable.
`timescale 1ns/1ps
`default_nettype none
interface refresh_link_if;
  logic pin_level;
  logic dev_pin_out;
  logic dev_pin_oe;
  logic src_pin_out;
  logic src_pin_oe;
  modport device (
    input pin_level,
    output dev_pin_out,
    output dev_pin_oe
  );
  modport source (
    input pin_level,
    output src_pin_out,
    output src_pin_oe
  );
endinterface
`default_nettype wire

//--- refresh_sequencer.sv
// Purpose: Refresh sequencer driving sample-and-hold switches of ten channels.
// Assumes: Pin input is asynchronous and is synchronised here.
// Notes: Switch outputs are one-hot per channel, closed while clock is low.
// ==========================================================================
// Behaviour
// - Switches follow selected internal or external clock
// - Clock low: selected channel's switches closed
// - Clock high: all refresh switches open
// - Each channel refreshed once per ten cycles
// - New value reaches output within 1-10 cycles
// - Falling edge starts channel, next one cycle later
// - External clock at most 70 kHz
// - External pulses at least 4 us wide
// - External duty cycle above 30 percent
// - External clock delayed from load changes
// - Internal for fixed load, external for transient
// - Power-up: internal oscillator, pin high impedance
// - Select bit high external, low internal
// - Internal oscillator near 21 kHz, may drive pin
`timescale 1ns/1ps
`default_nettype none
module refresh_sequencer
  import refresh_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic clock_source_select_bit_in,
  input wire logic select_load_in,
  input wire logic internal_drive_pin_in,
  refresh_link_if.device link,
  output logic [NUM_CHANNELS-1:0] refresh_switch_a_out,
  output logic [NUM_CHANNELS-1:0] refresh_switch_b_out,
  output logic [3:0] channel_index_out,
  output logic refresh_clock_out,
  output logic external_mode_out
);
  typedef enum logic [0:0] {
    MODE_INTERNAL = 1'b0,
    MODE_EXTERNAL = 1'b1
  } clk_mode_t;

  clk_mode_t mode_q;
  logic drive_pin_q;
  logic [15:0] osc_cnt_q;
  logic osc_q;
  logic [2:0] pin_sync_q;
  logic ext_level_q;
  logic refresh_clk;
  logic refresh_clk_q;
  logic [3:0] index_q;
  logic [NUM_CHANNELS-1:0] sw_a_q;
  logic [NUM_CHANNELS-1:0] sw_b_q;
  logic pin_out_q;
  logic pin_oe_q;

  // ========================================================================
  // Clock source selection
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= MODE_INTERNAL;
      drive_pin_q <= 1'b0;
    end else if (enable_in && select_load_in) begin
      mode_q <= clock_source_select_bit_in ? MODE_EXTERNAL
                                           : MODE_INTERNAL;
      drive_pin_q <= internal_drive_pin_in;
    end
  end

  // ========================================================================
  // Internal oscillator
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_cnt_q <= 16'h0000;
      osc_q <= 1'b1;
    end else if (enable_in) begin
      if (osc_cnt_q == 16'(INT_HALF_CYCLES - 1)) begin
        osc_cnt_q <= 16'h0000;
        osc_q <= ~osc_q;
      end else begin
        osc_cnt_q <= osc_cnt_q + 16'h0001;
      end
    end
  end

  // ========================================================================
  // External pin synchroniser; a level change counts once stages 2 and 3
  // agree, which also rejects a single-cycle glitch.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_sync_q <= 3'h7;
      ext_level_q <= 1'b1;
    end else if (enable_in) begin
      pin_sync_q <= {pin_sync_q[1:0], link.pin_level};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        ext_level_q <= pin_sync_q[2];
      end
    end
  end

  assign refresh_clk = (mode_q == MODE_EXTERNAL) ? ext_level_q
                                                 : osc_q;

  // ========================================================================
  // Channel rotation on falling refresh clock edges
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      refresh_clk_q <= 1'b1;
      index_q <= FIRST_CHANNEL;
    end else if (enable_in) begin
      refresh_clk_q <= refresh_clk;
      if (refresh_clk_q && !refresh_clk) begin
        // Every fall steps the index, so the first fall after reset refreshes channel 1.
        index_q <= (index_q == LAST_CHANNEL) ? FIRST_CHANNEL
                                             : index_q + 4'h1;
      end
    end
  end

  // ========================================================================
  // Switch drive. The index is updated in the same cycle the low phase is
  // seen, so switches close on the channel that the new edge selects. Any
  // loaded value therefore appears within ten cycles of the rotation.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sw_a_q <= '0;
      sw_b_q <= '0;
    end else if (enable_in) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        sw_a_q[i] <= !refresh_clk_q && (index_q == 4'(i));
        sw_b_q[i] <= !refresh_clk_q && (index_q == 4'(i));
      end
    end
  end

  // ========================================================================
  // Pin drive: only in internal mode, and only when asked to.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else if (enable_in) begin
      pin_out_q <= osc_q;
      pin_oe_q <= (mode_q == MODE_INTERNAL) && drive_pin_q;
    end
  end

  assign link.dev_pin_out = pin_out_q;
  assign link.dev_pin_oe = pin_oe_q;
  assign refresh_switch_a_out = sw_a_q;
  assign refresh_switch_b_out = sw_b_q;
  assign channel_index_out = index_q;
  assign refresh_clock_out = refresh_clk_q;
  assign external_mode_out = (mode_q == MODE_EXTERNAL);
endmodule
`default_nettype wire

//--- refresh_clock_source.sv
// Purpose: External refresh clock source synchronised to a load strobe.
// Assumes: High and low widths are programmed within the documented limits.
// Notes: A load strobe starts a low phase when its delay ends in a high phase at least the minimum
//        pulse long, so rising edges stay clear of load changes.
`timescale 1ns/1ps
`default_nettype none
module refresh_clock_source
  import refresh_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic run_in,
  input wire logic load_strobe_in,
  input wire logic [15:0] low_cycles_in,
  input wire logic [15:0] high_cycles_in,
  input wire logic [15:0] delay_cycles_in,
  refresh_link_if.source link,
  output logic external_refresh_clock_out,
  output logic limits_ok_out
);
  logic [15:0] cnt_q;
  logic [15:0] dly_q;
  logic dly_run_q;
  logic clk_q;
  logic ok_q;
  logic [15:0] lo_w;
  logic [15:0] hi_w;

  // ========================================================================
  // Widths are clamped up to the minimum pulse so a bad setting cannot
  // starve the hold capacitors.
  always_comb begin
    lo_w = (low_cycles_in < 16'(EXT_MIN_PULSE_CYCLES))
         ? 16'(EXT_MIN_PULSE_CYCLES) : low_cycles_in;
    hi_w = (high_cycles_in < 16'(EXT_MIN_PULSE_CYCLES))
         ? 16'(EXT_MIN_PULSE_CYCLES) : high_cycles_in;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dly_q <= 16'h0000;
      dly_run_q <= 1'b0;
    end else if (enable_in) begin
      if (load_strobe_in) begin
        dly_q <= delay_cycles_in;
        dly_run_q <= 1'b1;
      end else if (dly_run_q && dly_q != 16'h0000) begin
        dly_q <= dly_q - 16'h0001;
      end else begin
        dly_run_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Clock generator: a delayed load strobe ending in a high phase at least the minimum pulse long forces a fresh low phase.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 16'h0000;
      clk_q <= 1'b1;
    end else if (enable_in) begin
      if (!run_in) begin
        clk_q <= 1'b1;
        cnt_q <= 16'h0000;
      end else if (dly_run_q && dly_q == 16'h0000 && clk_q &&
                   cnt_q + 16'h0001 >= 16'(EXT_MIN_PULSE_CYCLES)) begin
        // The forced fall may cut the high phase short, but never below
        // the minimum pulse, so the hold capacitors still charge fully.
        clk_q <= 1'b0;
        cnt_q <= 16'h0000;
      end else if (cnt_q + 16'h0001 >= (clk_q ? hi_w : lo_w)) begin
        clk_q <= ~clk_q;
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // ========================================================================
  // Limit check: period within 70 kHz and each phase above 30 percent.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ok_q <= 1'b0;
    end else if (enable_in) begin
      ok_q <= (32'(lo_w) + 32'(hi_w) >= 32'(EXT_MIN_PERIOD_CYCLES)) &&
              (32'(lo_w) * 32'd100 >
               (32'(lo_w) + 32'(hi_w)) * 32'(EXT_MIN_DUTY_PCT)) &&
              (32'(hi_w) * 32'd100 >
               (32'(lo_w) + 32'(hi_w)) * 32'(EXT_MIN_DUTY_PCT));
    end
  end

  assign link.src_pin_out = clk_q;
  assign link.src_pin_oe = run_in;
  assign external_refresh_clock_out = clk_q;
  assign limits_ok_out = ok_q;
endmodule
`default_nettype wire

//--- refresh_checker.sv
// Purpose: Assertions on the refresh link and the switch outputs.
// Assumes: One 50 MHz clock and an async active-low reset.
// Notes: Switches lag the registered refresh clock by one cycle.
`timescale 1ns/1ps
`default_nettype none
module refresh_checker
  import refresh_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic pin_level,
  input wire logic dev_pin_oe,
  input wire logic src_pin_out,
  input wire logic src_pin_oe,
  input wire logic [NUM_CHANNELS-1:0] refresh_switch_a_out,
  input wire logic [NUM_CHANNELS-1:0] refresh_switch_b_out,
  input wire logic [3:0] channel_index_out,
  input wire logic refresh_clock_out,
  input wire logic external_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================================
  // Phase counters
  logic [15:0] hold_q;
  logic [15:0] src_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      hold_q <= 16'h0000;
    else
      hold_q <= $changed(refresh_clock_out) ? 16'h0000 : hold_q + 16'h0001;
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      src_q <= 16'h0000;
    else
      src_q <= $changed(src_pin_out) ? 16'h0000 : src_q + 16'h0001;
  end
  // ==========================================================================
  // Properties
  property p_closed_low;
    !$past(refresh_clock_out) |-> refresh_switch_b_out == refresh_switch_a_out
      && refresh_switch_a_out == (10'h001 << $past(channel_index_out));
  endproperty
  a_closed_low: assert property (p_closed_low)
    else $error("switches not closed on the selected channel");
  property p_open_high;
    $past(refresh_clock_out) |-> refresh_switch_a_out == 10'h000
      && refresh_switch_b_out == 10'h000;
  endproperty
  a_open_high: assert property (p_open_high)
    else $error("switches closed while refresh clock high");
  property p_step;
    $fell(refresh_clock_out) |-> channel_index_out ==
      (($past(channel_index_out) == LAST_CHANNEL) ? FIRST_CHANNEL :
      $past(channel_index_out) + 4'h1);
  endproperty
  a_step: assert property (p_step)
    else $error("channel index did not step on the fall");
  property p_hold;
    !$fell(refresh_clock_out) |-> $stable(channel_index_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("channel index moved without a fall");
  property p_ext_fall;
    external_mode_out && $fell(pin_level) |->
      ##[2:6] (!refresh_clock_out || !external_mode_out);
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("refresh clock did not follow pin low");
  property p_ext_rise;
    external_mode_out && $rose(pin_level) |->
      ##[2:6] (refresh_clock_out || !external_mode_out);
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("refresh clock did not follow pin high");
  property p_pin_free;
    external_mode_out && $past(external_mode_out) |-> !dev_pin_oe;
  endproperty
  a_pin_free: assert property (p_pin_free)
    else $error("device drives pin in external mode");
  property p_int_rate;
    !external_mode_out |-> hold_q <= INT_HALF_CYCLES + 1;
  endproperty
  a_int_rate: assert property (p_int_rate)
    else $error("internal refresh phase too long");
  property p_src_width;
    src_pin_oe && $past(src_pin_oe) && $changed(src_pin_out) |->
      src_q >= EXT_MIN_PULSE_CYCLES - 1;
  endproperty
  a_src_width: assert property (p_src_width)
    else $error("source pulse shorter than minimum");
endmodule
`default_nettype wire

//--- dac_output_refresh_sequencer_tb_top.sv
// Purpose: Self-checking bench joining sequencer and clock source.
// Assumes: 50 MHz clock; inputs change on the falling edge.
// Notes: Index checks run in the background on every refresh fall.
`timescale 1ns/1ps
`default_nettype none
module dac_output_refresh_sequencer_tb_top;
  import refresh_pkg::*;
  typedef struct packed {logic sel; logic drive; logic mode; logic oe;} row_t;
  row_t rows [4] = '{4'b0000, 4'b0101, 4'b1010, 4'b1110};
  logic clk_in = 0, reset_n_in = 0, sel = 0, load = 0, drive = 0;
  logic run = 0, strobe = 0, rco_prev = 1;
  logic [15:0] low_w = EXT_DEFAULT_LOW, high_w = EXT_DEFAULT_HIGH;
  logic [NUM_CHANNELS-1:0] sw_a, sw_b;
  logic [3:0] idx, exp_idx = 4'h0;
  logic rco, ext_mode, ext_clk, lim_ok;
  int err_count = 0, n_tests = 0, falls = 0;
  refresh_link_if link ();
  // An undriven pin is pulled high.
  assign link.pin_level = link.dev_pin_oe ? link.dev_pin_out :
    link.src_pin_oe ? link.src_pin_out : 1'b1;
  refresh_sequencer refresh_sequencer_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .enable_in(1'b1),
    .clock_source_select_bit_in(sel), .select_load_in(load),
    .internal_drive_pin_in(drive), .link(link),
    .refresh_switch_a_out(sw_a), .refresh_switch_b_out(sw_b),
    .channel_index_out(idx), .refresh_clock_out(rco),
    .external_mode_out(ext_mode));
  refresh_clock_source refresh_clock_source_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .enable_in(1'b1), .run_in(run),
    .load_strobe_in(strobe), .low_cycles_in(low_w),
    .high_cycles_in(high_w), .delay_cycles_in(EXT_DEFAULT_DELAY),
    .link(link), .external_refresh_clock_out(ext_clk),
    .limits_ok_out(lim_ok));
  refresh_checker refresh_checker_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .pin_level(link.pin_level),
    .dev_pin_oe(link.dev_pin_oe), .src_pin_out(link.src_pin_out),
    .src_pin_oe(link.src_pin_oe), .refresh_switch_a_out(sw_a),
    .refresh_switch_b_out(sw_b), .channel_index_out(idx),
    .refresh_clock_out(rco), .external_mode_out(ext_mode));
  // ==========================================================================
  // Checking tasks
  task automatic chk_flag(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_vec(input string nm, input logic [9:0] e,
    input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_falls(input int n);
    int t;
    t = falls + n;
    for (int i = 0; i < n * 2600 && falls < t; i++) @(posedge clk_in);
    #2;
    chk_flag("falls_seen", 1'b1, falls >= t);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    #1;
    if (!reset_n_in)
      exp_idx = FIRST_CHANNEL;
    else if (rco_prev && !rco) begin
      exp_idx = (exp_idx == LAST_CHANNEL) ? FIRST_CHANNEL : exp_idx + 4'h1;
      falls++;
      chk_vec("index", {6'h00, exp_idx}, {6'h00, idx});
    end
    rco_prev = rco;
  end
  initial forever #10 clk_in = ~clk_in;
  initial begin
    #1_900_000;
    err_count++;
    conclude();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(negedge clk_in);
    reset_n_in = 1;
    foreach (rows[i]) begin
      @(negedge clk_in);
      sel = rows[i].sel;
      drive = rows[i].drive;
      run = rows[i].sel;
      load = 1;
      @(negedge clk_in);
      load = 0;
      wait_falls(10);
      chk_flag("ext_mode", rows[i].mode, ext_mode);
      chk_flag("pin_oe", rows[i].oe, link.dev_pin_oe);
      @(posedge clk_in);
      #1;
      chk_vec("switch_a", 10'h001 << idx, sw_a);
      chk_vec("switch_b", 10'h001 << idx, sw_b);
    end
    // A strobe late in the high phase must force an early fall.
    wait (link.src_pin_out == 1'b0);
    wait (link.src_pin_out == 1'b1);
    repeat (250) @(negedge clk_in);
    strobe = 1;
    @(negedge clk_in);
    strobe = 0;
    repeat (EXT_DEFAULT_DELAY + 4) @(negedge clk_in);
    chk_flag("forced_low", 1'b0, link.src_pin_out);
    chk_flag("ext_clk_low", 1'b0, ext_clk);
    chk_flag("limits_ok", 1'b1, lim_ok);
    low_w = 16'h00C8;
    high_w = 16'h00C8;
    repeat (1200) @(negedge clk_in);
    chk_flag("limits_fast", 1'b0, lim_ok);
    reset_n_in = 0;
    @(negedge clk_in);
    chk_flag("mode_rst", 1'b0, ext_mode);
    chk_flag("oe_rst", 1'b0, link.dev_pin_oe);
    chk_vec("idx_rst", 10'h000, {6'h00, idx});
    chk_vec("sw_rst", 10'h000, sw_a);
    conclude();
  end
endmodule
`default_nettype wire
